// file: logic/psr_pkg.sv
package psr_pkg;

    // bit positions inside the processor status byte
    localparam int unsigned BIT_IND_BANK  = 7;  // indirect bank select
    localparam int unsigned BIT_DIR_HIGH  = 6;  // direct bank select high
    localparam int unsigned BIT_DIR_LOW   = 5;  // direct bank select low
    localparam int unsigned BIT_WDOG      = 4;  // watchdog expiry flag
    localparam int unsigned BIT_LOWPWR    = 3;  // low-power entry flag
    localparam int unsigned BIT_ZERO      = 2;  // zero flag
    localparam int unsigned BIT_NIBBLE    = 1;  // nibble overflow flag
    localparam int unsigned BIT_CARRY     = 0;  // carry flag

    // register address inside the data memory map (any bank mirror picks it)
    localparam logic [6:0] ADDR_STATUS    = 7'h03;  // low seven address bits
    localparam logic [7:0] RST_STATUS     = 8'h18;  // bank bits 0, cause flags 1, arithmetic 0
    localparam logic [7:0] MASK_SW_WRITE  = 8'hE7;  // cause flags never take software data
    localparam logic [7:0] MASK_ARITH     = 8'h07;  // zero, nibble and carry flags

    // one-cycle update request from the execution unit
    typedef struct packed {
        logic       wr_en;      // write result to a data memory register
        logic [8:0] wr_addr;    // full 9-bit data memory address
        logic [7:0] wr_data;    // result value
        logic       upd_zero;   // instruction updates zero flag
        logic       upd_carry;  // instruction updates nibble and carry flags
        logic       zero_val;   // zero result
        logic       nib_val;    // carry (or no-borrow) out of bit 3
        logic       carry_val;  // carry (or no-borrow) out of bit 7
        logic       is_sub;     // subtract operation, flags carry no-borrow sense
    } psr_exec_s;

    // hardware reset-cause events
    typedef struct packed {
        logic wdog_kick;        // watchdog kick operation executed
        logic sleep;            // sleep instruction executed
        logic wdog_expire;      // watchdog timer expired
    } psr_event_s;

endpackage

// file: logic/psr_status_reg.sv
`timescale 1ns/10ps
module psr_status_reg
    import psr_pkg::*;
(
    input  wire logic       CLK_IN,          // 50 MHz instruction clock
    input  wire logic       RST_IN,          // async power-on reset, active high
    input  wire psr_exec_s  EXEC_IN,         // execution unit result and flags
    input  wire psr_event_s EVENT_IN,        // reset-cause events, same clock
    input  wire logic       RD_EN_IN,        // read strobe
    input  wire logic [8:0] RD_ADDR_IN,      // read address
    input  wire logic [8:0] DIRECT_ADDR_IN,  // 7-bit direct operand (low bits used)
    input  wire logic [7:0] INDIRECT_PTR_IN, // indirect pointer byte
    output logic      [7:0] RD_DATA_OUT,     // read data, one cycle after strobe
    output logic      [7:0] STATUS_OUT,      // live status byte
    output logic      [8:0] DIRECT_EA_OUT,   // registered direct effective address
    output logic      [8:0] INDIRECT_EA_OUT  // registered indirect effective address
);

    logic [7:0] status_ff;      // the status byte
    logic [7:0] nxt_status;     // its next value
    logic [7:0] rd_data_ff;     // read data holding register
    logic [8:0] dir_ea_ff;      // direct address after bank mapping
    logic [8:0] ind_ea_ff;      // indirect address after bank mapping
    logic       hit_wr;         // write targets the status register
    logic       hit_rd;         // read targets the status register
    logic [7:0] wr_mask;        // bits that software data may reach this cycle

    // status appears in every bank, so only the low seven bits are decoded
    assign hit_wr = EXEC_IN.wr_en && (EXEC_IN.wr_addr[6:0] == ADDR_STATUS);
    assign hit_rd = RD_ADDR_IN[6:0] == ADDR_STATUS;

    // write mask: an instruction that touches any arithmetic flag loses the
    // written value for all three of them, not only for the flags it computes;
    // otherwise a clear op would wipe the untouched nibble and carry flags
    always_comb begin
        if (EXEC_IN.upd_zero || EXEC_IN.upd_carry) begin
            // flag-updating instruction: only the bank bits take data
            wr_mask = MASK_SW_WRITE & ~MASK_ARITH;
        end else begin
            // plain store: bank bits and arithmetic flags take data
            wr_mask = MASK_SW_WRITE;
        end
    end

    // next status: software data first, then computed flags, then hardware events
    always_comb begin
        nxt_status = status_ff;
        if (hit_wr) begin
            // a clear op arrives here as data zero with upd_zero set
            nxt_status = (status_ff & ~wr_mask) | (EXEC_IN.wr_data & wr_mask);
        end
        // computed flags override any written value for those bits
        if (EXEC_IN.upd_zero) begin
            nxt_status[BIT_ZERO] = EXEC_IN.zero_val;
        end
        if (EXEC_IN.upd_carry) begin
            // for subtraction the values come in no-borrow sense: 1 means no borrow
            nxt_status[BIT_NIBBLE] = EXEC_IN.nib_val;
            nxt_status[BIT_CARRY]  = EXEC_IN.carry_val;
        end
        // hardware events; expiry wins over kick since it is the later cause
        if (EVENT_IN.wdog_kick) begin
            nxt_status[BIT_WDOG]   = 1'b1;
            nxt_status[BIT_LOWPWR] = 1'b1;
        end
        if (EVENT_IN.sleep) begin
            nxt_status[BIT_WDOG]   = 1'b1;
            nxt_status[BIT_LOWPWR] = 1'b0;
        end
        if (EVENT_IN.wdog_expire) begin
            nxt_status[BIT_WDOG] = 1'b0;
        end
    end

    // status storage; arithmetic flags reset to zero since undefined is not synthesizable
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            status_ff <= RST_STATUS;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // read port: data stands in the cycle after the strobe only
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rd_data_ff <= 8'h00;
        end else if (RD_EN_IN && hit_rd) begin
            rd_data_ff <= status_ff;
        end else begin
            rd_data_ff <= 8'h00;     // unmapped or idle reads return zero
        end
    end

    // bank mapping of addresses, registered so outputs come from flops
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            dir_ea_ff <= 9'h000;
            ind_ea_ff <= 9'h000;
        end else begin
            dir_ea_ff <= {nxt_status[BIT_DIR_HIGH], nxt_status[BIT_DIR_LOW], DIRECT_ADDR_IN[6:0]};
            ind_ea_ff <= {nxt_status[BIT_IND_BANK], INDIRECT_PTR_IN};
        end
    end

    assign RD_DATA_OUT     = rd_data_ff;
    assign STATUS_OUT      = status_ff;
    assign DIRECT_EA_OUT   = dir_ea_ff;
    assign INDIRECT_EA_OUT = ind_ea_ff;

    // software data never reaches the reset-cause flags without an event
    property p_cause_hold;
        @(posedge CLK_IN) disable iff (RST_IN)
        !(EVENT_IN.wdog_kick || EVENT_IN.sleep || EVENT_IN.wdog_expire)
            |=> (status_ff[4:3] == $past(status_ff[4:3]));
    endproperty
    a_cause_hold: assert property (p_cause_hold) else $error("cause flag changed without event");

    property p_computed_wins;
        @(posedge CLK_IN) disable iff (RST_IN)
        (hit_wr && EXEC_IN.upd_carry) |=> (status_ff[1:0] == $past({EXEC_IN.nib_val, EXEC_IN.carry_val}));
    endproperty
    a_computed_wins: assert property (p_computed_wins) else $error("written value beat computed carry");

    property p_zero_flag;
        @(posedge CLK_IN) disable iff (RST_IN)
        EXEC_IN.upd_zero |=> (status_ff[BIT_ZERO] == $past(EXEC_IN.zero_val));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_clear_op;
        @(posedge CLK_IN) disable iff (RST_IN)
        (hit_wr && EXEC_IN.wr_data == 8'h00 && EXEC_IN.upd_zero && EXEC_IN.zero_val && !EXEC_IN.upd_carry)
            |=> (status_ff[7:5] == 3'h0) && status_ff[BIT_ZERO] && (status_ff[1:0] == $past(status_ff[1:0]));
    endproperty
    a_clear_op: assert property (p_clear_op) else $error("clear op result wrong");

    sequence s_sleep;
        EVENT_IN.sleep && !EVENT_IN.wdog_expire;
    endsequence
    property p_sleep;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_sleep |=> (status_ff[4:3] == 2'b10);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

    property p_expire;
        @(posedge CLK_IN) disable iff (RST_IN)
        EVENT_IN.wdog_expire |=> !status_ff[BIT_WDOG];
    endproperty
    a_expire: assert property (p_expire) else $error("expiry did not clear flag");

    property p_direct_map;
        @(posedge CLK_IN) disable iff (RST_IN)
        1'b1 |=> (dir_ea_ff[8:7] == status_ff[6:5]);
    endproperty
    a_direct_map: assert property (p_direct_map) else $error("direct bank mapping wrong");

    property p_indirect_map;
        @(posedge CLK_IN) disable iff (RST_IN)
        1'b1 |=> (ind_ea_ff[8] == status_ff[7]);
    endproperty
    a_indirect_map: assert property (p_indirect_map) else $error("indirect bank mapping wrong");

    property p_sw_write;
        @(posedge CLK_IN) disable iff (RST_IN)
        (hit_wr && !EXEC_IN.upd_zero && !EXEC_IN.upd_carry)
            |=> (status_ff[7:5] == $past(EXEC_IN.wr_data[7:5])) && (status_ff[2:0] == $past(EXEC_IN.wr_data[2:0]));
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("status write lost");

    // a zero-only update aimed at status must not let data reach
    // the nibble and carry flags either
    property p_arith_write_blocked;
        @(posedge CLK_IN) disable iff (RST_IN)
        (hit_wr && EXEC_IN.upd_zero && !EXEC_IN.upd_carry)
            |=> (status_ff[1:0] == $past(status_ff[1:0]));
    endproperty
    a_arith_write_blocked: assert property (p_arith_write_blocked) else $error("data reached flags");

    // a lone kick sets both reset-cause flags
    // (kick without sleep, with or without expiry, is the only event case that raises the low-power flag)
    property p_kick;
        @(posedge CLK_IN) disable iff (RST_IN)
        (EVENT_IN.wdog_kick && !EVENT_IN.sleep && !EVENT_IN.wdog_expire)
            |=> (status_ff[4:3] == 2'b11);
    endproperty
    a_kick: assert property (p_kick) else $error("kick flags wrong");

    // kick and sleep together: sleep is the later cause
    property p_kick_sleep;
        @(posedge CLK_IN) disable iff (RST_IN)
        (EVENT_IN.wdog_kick && EVENT_IN.sleep && !EVENT_IN.wdog_expire)
            |=> (status_ff[4:3] == 2'b10);
    endproperty
    a_kick_sleep: assert property (p_kick_sleep) else $error("kick and sleep flags wrong");

    // expiry alone leaves the low-power flag where it was
    property p_expire_lowpwr;
        @(posedge CLK_IN) disable iff (RST_IN)
        (EVENT_IN.wdog_expire && !EVENT_IN.wdog_kick && !EVENT_IN.sleep)
            |=> (status_ff[BIT_LOWPWR] == $past(status_ff[BIT_LOWPWR]));
    endproperty
    a_expire_lowpwr: assert property (p_expire_lowpwr) else $error("expiry moved low-power flag");

    // nibble flag follows the computed carry out of bit three
    property p_nibble_flag;
        @(posedge CLK_IN) disable iff (RST_IN)
        EXEC_IN.upd_carry |=> (status_ff[BIT_NIBBLE] == $past(EXEC_IN.nib_val));
    endproperty
    a_nibble_flag: assert property (p_nibble_flag) else $error("nibble flag wrong");

    // carry flag follows the computed carry out of bit seven
    property p_carry_flag;
        @(posedge CLK_IN) disable iff (RST_IN)
        EXEC_IN.upd_carry |=> (status_ff[BIT_CARRY] == $past(EXEC_IN.carry_val));
    endproperty
    a_carry_flag: assert property (p_carry_flag) else $error("carry flag wrong");

    // subtraction: values arrive in no-borrow sense and are stored as given,
    // so a stored one means no borrow; no inversion happens here
    sequence s_sub_update;
        EXEC_IN.upd_carry && EXEC_IN.is_sub;
    endsequence
    property p_sub_sense;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_sub_update |=> (status_ff[1:0] == $past({EXEC_IN.nib_val, EXEC_IN.carry_val}));
    endproperty
    a_sub_sense: assert property (p_sub_sense) else $error("borrow flags wrong");

    // arithmetic flags hold when nothing writes or computes them
    property p_flags_hold;
        @(posedge CLK_IN) disable iff (RST_IN)
        (!hit_wr && !EXEC_IN.upd_zero && !EXEC_IN.upd_carry)
            |=> (status_ff[2:0] == $past(status_ff[2:0]));
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("arithmetic flags drifted");

    // bank bits change only through a write to status
    property p_bank_hold;
        @(posedge CLK_IN) disable iff (RST_IN)
        !hit_wr |=> (status_ff[7:5] == $past(status_ff[7:5]));
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank bits drifted");

    // a bank write shows on the direct address in the same edge,
    // since the mapping reads the next status value
    property p_direct_follows_write;
        @(posedge CLK_IN) disable iff (RST_IN)
        hit_wr |=> (dir_ea_ff[8:7] == $past(EXEC_IN.wr_data[6:5]));
    endproperty
    a_direct_follows_write: assert property (p_direct_follows_write) else $error("direct bank lagged");

    // same for the indirect half select
    property p_indirect_follows_write;
        @(posedge CLK_IN) disable iff (RST_IN)
        hit_wr |=> (ind_ea_ff[8] == $past(EXEC_IN.wr_data[7]));
    endproperty
    a_indirect_follows_write: assert property (p_indirect_follows_write) else $error("indirect bank lagged");

    // the low seven direct address bits pass through unchanged
    property p_direct_low;
        @(posedge CLK_IN) disable iff (RST_IN)
        1'b1 |=> (dir_ea_ff[6:0] == $past(DIRECT_ADDR_IN[6:0]));
    endproperty
    a_direct_low: assert property (p_direct_low) else $error("direct offset wrong");

    // the pointer byte passes through unchanged
    property p_indirect_ptr;
        @(posedge CLK_IN) disable iff (RST_IN)
        1'b1 |=> (ind_ea_ff[7:0] == $past(INDIRECT_PTR_IN));
    endproperty
    a_indirect_ptr: assert property (p_indirect_ptr) else $error("indirect pointer wrong");

    // a status read returns the byte held at the strobe edge
    property p_read_data;
        @(posedge CLK_IN) disable iff (RST_IN)
        (RD_EN_IN && hit_rd) |=> (rd_data_ff == $past(status_ff));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    // read data stands one cycle only; idle or other addresses give zero
    property p_read_idle;
        @(posedge CLK_IN) disable iff (RST_IN)
        !(RD_EN_IN && hit_rd) |=> (rd_data_ff == 8'h00);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not idle");

    // reset leaves bank bits clear and cause flags set; checked one edge
    // later so an unknown start before the first edge does not matter
    property p_reset_value;
        @(posedge CLK_IN)
        RST_IN |=> (status_ff == RST_STATUS);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

endmodule

// file: bench/psr_status_reg_tb.sv
`timescale 1ns/10ps
module psr_status_reg_tb;
    import psr_pkg::*;

    // one table row: request, events and the status byte that must follow
    typedef struct packed {
        psr_exec_s  ex;   // execution request
        psr_event_s ev;   // reset-cause events
        logic [7:0] exp;  // expected status after the edge
    } psr_row_s;

    logic       clk = 1'b0;      // 50 MHz clock
    logic       rst = 1'b1;      // async reset
    psr_exec_s  exec_in = '0;    // execution stimulus
    psr_event_s event_in = '0;   // event stimulus
    logic       rd_en = 1'b0;    // read strobe
    logic [8:0] rd_addr = 9'h183; // read address
    logic [7:0] rd_data;         // read data seen
    logic [7:0] status;          // live status seen
    logic [8:0] dir_ea;          // direct effective address
    logic [8:0] ind_ea;          // indirect effective address
    psr_row_s   rows [13];       // ordinary cases
    int         mismatches = 0;  // failed compares
    int         check_count = 0; // compares made
    int         cycles = 0;      // hang guard

    always #10 clk = ~clk;

    psr_status_reg uut (
        .CLK_IN          (clk),
        .RST_IN          (rst),
        .EXEC_IN         (exec_in),
        .EVENT_IN        (event_in),
        .RD_EN_IN        (rd_en),
        .RD_ADDR_IN      (rd_addr),
        .DIRECT_ADDR_IN  (9'h0DA),
        .INDIRECT_PTR_IN (8'h3C),
        .RD_DATA_OUT     (rd_data),
        .STATUS_OUT      (status),
        .DIRECT_EA_OUT   (dir_ea),
        .INDIRECT_EA_OUT (ind_ea)
    );

    // single place where the run ends
    task automatic conclude();
        if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // case-equality compare so unknowns never pass
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // the whole run needs about 46 cycles; anything far beyond is a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        // fields: wr_en, addr, data, {upd_z,upd_c,z,nib,c,sub}, {kick,sleep,expire}, expected
        rows[0]  = {1'h1, 9'h003, 8'hE7, 6'h00, 3'h0, 8'hFF};
        rows[1]  = {1'h1, 9'h183, 8'h00, 6'h28, 3'h0, 8'h1F};
        rows[2]  = {1'h0, 9'h000, 8'h00, 6'h00, 3'h2, 8'h17};
        rows[3]  = {1'h0, 9'h000, 8'h00, 6'h00, 3'h1, 8'h07};
        rows[4]  = {1'h0, 9'h000, 8'h00, 6'h00, 3'h4, 8'h1F};
        rows[5]  = {1'h0, 9'h000, 8'h00, 6'h34, 3'h0, 8'h1A};
        rows[6]  = {1'h1, 9'h083, 8'h65, 6'h39, 3'h0, 8'h7C};
        rows[7]  = {1'h1, 9'h103, 8'hA4, 6'h00, 3'h0, 8'hBC};
        rows[8]  = {1'h1, 9'h003, 8'h44, 6'h00, 3'h0, 8'h5C};
        rows[9]  = {1'h1, 9'h004, 8'h00, 6'h00, 3'h0, 8'h5C};
        rows[10] = {1'h0, 9'h000, 8'h00, 6'h00, 3'h3, 8'h44};
        rows[11] = {1'h1, 9'h003, 8'h1C, 6'h00, 3'h0, 8'h04};
        rows[12] = {1'h0, 9'h000, 8'h00, 6'h00, 3'h4, 8'h1C};
        @(posedge clk);
        #1;
        chk("reset status", 9'h018, {1'b0, status});
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // apply a row, then read it back through the mirror address
        for (int i = 0; i < 13; i++) begin
            @(posedge clk);
            exec_in <= rows[i].ex;
            event_in <= rows[i].ev;
            @(posedge clk);
            exec_in <= '0;
            event_in <= '0;
            rd_en <= 1'b1;
            #1;
            chk("status", {1'b0, rows[i].exp}, {1'b0, status});
            chk("direct ea", {rows[i].exp[6:5], 7'h5A}, dir_ea);
            chk("indirect ea", {rows[i].exp[7], 8'h3C}, ind_ea);
            @(posedge clk);
            rd_en <= 1'b0;
            #1;
            chk("read data", {1'b0, rows[i].exp}, {1'b0, rd_data});
        end
        // a read of another register must leave the read data at zero
        @(posedge clk);
        rd_addr <= 9'h084;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("other read", 9'h000, {1'b0, rd_data});
        // reset again in mid-run: bank bits clear, cause flags set
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk("mid reset status", 9'h018, {1'b0, status});
        conclude();
    end
endmodule
